/* logic/interrupt_exception_sequencer.sv */
// Interrupt and exception sequencer: classify, prioritise, save, vector and dispatch
`timescale 1ns/100ps

// Functional notes
// - Hardware interrupts taken only at instruction boundaries
// - Interrupt return address is next instruction
// - Faults serviced before the faulting instruction executes
// - Fault return address includes leading prefix bytes
// - Traps reported after instruction completes
// - Severe errors reported as imprecise aborts
// - Software interrupts use the exception path
// - 256 vectors index a software-defined table
// - Vectors below 32 reserved, 224 free
// - Real entry 4 bytes, protected 8 bytes
// - Push address and flags, vector, fetch, run
// - Interrupt return restores state and resumes
// - Exception vectors internal, software from instruction
// - Maskable interrupt fetches vector by acknowledge cycle
// - Non-maskable interrupt always uses vector 2
// - Maskable request honoured only with enable flag
// - Non-maskable wins over maskable at boundary
// - Non-maskable entry clears interrupt enable flag
// - One nested non-maskable request held until return
module interrupt_exception_sequencer
    import irq_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // External request pins
    input wire logic nmi_in_i,
    input wire logic maskable_irq_in_i,
    // Execution core status
    input wire logic instr_boundary_i,
    input wire logic [ADDR_W-1:0] instr_start_addr_i,
    input wire logic [ADDR_W-1:0] next_instr_addr_i,
    input wire logic prot_mode_i,
    input wire logic [ADDR_W-1:0] table_base_i,
    // Exception and software interrupt requests
    input wire logic fault_i,
    input wire logic [VEC_W-1:0] fault_vec_i,
    input wire logic trap_i,
    input wire logic [VEC_W-1:0] trap_vec_i,
    input wire logic abort_i,
    input wire logic [VEC_W-1:0] abort_vec_i,
    input wire logic soft_int_i,
    input wire logic [VEC_W-1:0] soft_int_vec_i,
    // Enable flag control and interrupt return
    input wire logic if_set_i,
    input wire logic if_clear_i,
    input wire logic interrupt_return_instr_i,
    input wire logic [ADDR_W-1:0] ret_addr_i,
    input wire logic ret_if_i,
    // Stack push handshake
    output logic push_valid_o,
    input wire logic push_ready_i,
    output logic [ADDR_W-1:0] push_addr_o,
    output logic push_if_o,
    // Interrupt acknowledge handshake
    output logic inta_req_o,
    input wire logic inta_done_i,
    input wire logic [VEC_W-1:0] inta_vec_i,
    // Vector table read handshake
    output logic table_rd_o,
    input wire logic table_ack_i,
    output logic [ADDR_W-1:0] table_addr_o,
    input wire logic [ENTRY_W-1:0] table_data_i,
    // Dispatch to the core
    output logic busy_o,
    output logic handler_go_o,
    output logic [FIELD16_W-1:0] handler_sel_o,
    output logic [ADDR_W-1:0] handler_off_o,
    output logic [VEC_W-1:0] vector_o,
    output logic [2:0] event_class_o,
    output logic vec_reserved_o,
    output logic if_flag_o,
    output logic nmi_active_o,
    output logic resume_o,
    output logic [ADDR_W-1:0] resume_addr_o
);
    logic [1:0] rst_sync; // Reset release chain
    logic rst_n; // Synchronised reset
    logic [1:0] pin_level; // Filtered pins: bit 1 non-maskable, bit 0 maskable
    logic nmi_level; // Filtered non-maskable pin
    logic nmi_level_d; // Previous filtered level for edge detect
    logic nmi_edge; // Rising edge of non-maskable pin
    logic nmi_pending; // One remembered non-maskable request
    logic nmi_active; // Inside a non-maskable handler
    logic if_flag; // Maskable interrupt enable
    seq_state_e state; // Sequencer state
    seq_state_e next_state; // Next sequencer state
    event_class_e cls; // Class of the event being entered
    event_class_e next_cls; // Class chosen this cycle
    logic [VEC_W-1:0] vector; // Vector of the event being entered
    logic [VEC_W-1:0] next_vec; // Vector chosen this cycle
    logic [ADDR_W-1:0] next_ret; // Return address chosen this cycle
    logic take_nmi; // Non-maskable request taken now
    logic take_irq; // Maskable request taken now
    logic accept; // An event starts now
    logic [ADDR_W-1:0] entry_addr; // Table entry address
    logic [FIELD16_W-1:0] dec_sel; // Decoded handler selector
    logic [ADDR_W-1:0] dec_off; // Decoded handler offset

    // Release reset through two flip-flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Filter both request pins
    pin_sync #(.WIDTH(2)) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .pin_i({nmi_in_i, maskable_irq_in_i}),
        .level_o(pin_level)
    );
    assign nmi_level = pin_level[1];

    // Table address and handler pointer decode
    vector_locator u_vector_locator (
        .prot_mode_i(prot_mode_i),
        .table_base_i(table_base_i),
        .vector_i(vector),
        .entry_i(table_data_i),
        .entry_addr_o(entry_addr),
        .handler_sel_o(dec_sel),
        .handler_off_o(dec_off)
    );

    // Edge detect on the filtered non-maskable level
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nmi_level_d <= 1'b0;
        end else begin
            nmi_level_d <= nmi_level;
        end
    end
    assign nmi_edge = nmi_level & ~nmi_level_d;

    // Event selection: abort, fault, then boundary events
    always_comb begin
        next_cls = CLS_NONE;
        next_vec = VEC_RESET;
        next_ret = next_instr_addr_i;
        take_nmi = 1'b0;
        take_irq = 1'b0;
        if (abort_i) begin
            // Imprecise: start of current instruction is only a hint
            next_cls = CLS_ABORT;
            next_vec = abort_vec_i;
            next_ret = instr_start_addr_i;
        end else if (fault_i) begin
            // Taken before execution, return to first prefix byte
            next_cls = CLS_FAULT;
            next_vec = fault_vec_i;
            next_ret = instr_start_addr_i;
        end else if (instr_boundary_i) begin
            if (trap_i) begin
                // Reported after completion, return to next instruction
                next_cls = CLS_TRAP;
                next_vec = trap_vec_i;
            end else if (soft_int_i) begin
                // Software interrupt rides the exception path
                next_cls = CLS_SOFT;
                next_vec = soft_int_vec_i;
            end else if ((nmi_pending || nmi_edge) && !nmi_active) begin
                // Non-maskable after trap and software, before maskable, fixed vector, no acknowledge
                next_cls = CLS_NMI;
                next_vec = VEC_NMI;
                take_nmi = 1'b1;
            end else if (pin_level[0] && if_flag) begin
                // Maskable only while enabled, vector from acknowledge
                next_cls = CLS_MASKABLE;
                take_irq = 1'b1;
            end
        end
    end
    assign accept = (state == ST_IDLE) && (next_cls != CLS_NONE) && !interrupt_return_instr_i;

    // Non-maskable request memory: one pending, edge wins over take
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nmi_pending <= 1'b0;
        end else if (nmi_edge) begin
            nmi_pending <= 1'b1;
        end else if (accept && take_nmi) begin
            nmi_pending <= 1'b0;
        end
    end

    // Non-maskable handler in progress until the first return
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nmi_active <= 1'b0;
        end else if (accept && take_nmi) begin
            nmi_active <= 1'b1;
        end else if (interrupt_return_instr_i) begin
            nmi_active <= 1'b0;
        end
    end

    // Interrupt enable flag: cleared on hardware entry, restored on return
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            if_flag <= 1'b0;
        end else if (accept && (take_nmi || take_irq)) begin
            if_flag <= 1'b0;
        end else if (interrupt_return_instr_i) begin
            if_flag <= ret_if_i;
        end else if (if_set_i) begin
            if_flag <= 1'b1;
        end else if (if_clear_i) begin
            if_flag <= 1'b0;
        end
    end

    // Latch the chosen event, its vector and the frame to push
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cls <= CLS_NONE;
            vector <= VEC_RESET;
            push_addr_o <= ADDR_RESET;
            push_if_o <= 1'b0;
        end else if (accept) begin
            cls <= next_cls;
            vector <= next_vec;
            push_addr_o <= next_ret;
            push_if_o <= if_flag;
        end else if (state == ST_ACK && inta_done_i) begin
            vector <= inta_vec_i;
        end
    end

    // Sequencer transitions: push, vector, fetch, dispatch
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                // Frame saved before the vector is obtained
                if (push_ready_i) begin
                    next_state = (cls == CLS_MASKABLE) ? ST_ACK : ST_FETCH;
                end
            end
            ST_ACK: begin
                // Wait for the controller to return its vector
                if (inta_done_i) begin
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // Read the handler pointer from the table
                if (table_ack_i) begin
                    next_state = ST_GO;
                end
            end
            ST_GO: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Capture the handler pointer when the table answers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            handler_sel_o <= SEL_RESET;
            handler_off_o <= ADDR_RESET;
        end else if (state == ST_FETCH && table_ack_i) begin
            handler_sel_o <= dec_sel;
            handler_off_o <= dec_off;
        end
    end

    // Return: resume at the saved address
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            resume_o <= 1'b0;
            resume_addr_o <= ADDR_RESET;
        end else begin
            resume_o <= interrupt_return_instr_i && (state == ST_IDLE);
            if (interrupt_return_instr_i) begin
                resume_addr_o <= ret_addr_i;
            end
        end
    end

    // Handshake and status outputs
    assign push_valid_o = (state == ST_PUSH);
    assign inta_req_o = (state == ST_ACK);
    assign table_rd_o = (state == ST_FETCH);
    assign table_addr_o = entry_addr;
    assign handler_go_o = (state == ST_GO);
    assign busy_o = (state != ST_IDLE);
    assign vector_o = vector;
    assign event_class_o = cls;
    assign vec_reserved_o = (vector < VEC_RESERVED_LIMIT);
    assign if_flag_o = if_flag;
    assign nmi_active_o = nmi_active;
endmodule : interrupt_exception_sequencer

/* logic/irq_seq_pkg.sv */
// Shared constants and types for the interrupt and exception sequencer
package irq_seq_pkg;
    // Vector numbering
    localparam int VEC_W = 8;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_RESERVED_LIMIT = 8'h20;
    localparam int VEC_COUNT = 256;
    // Address and entry widths
    localparam int ADDR_W = 32;
    localparam int ENTRY_W = 64;
    // Byte shift of the vector number into the table, per mode
    localparam int REAL_ENTRY_SHIFT = 2;
    localparam int PROT_ENTRY_SHIFT = 3;
    // Field positions of a real-mode entry
    localparam int RM_OFF_LSB = 0;
    localparam int RM_SEG_LSB = 16;
    // Field positions of a protected-mode descriptor
    localparam int PM_OFF_LO_LSB = 0;
    localparam int PM_SEL_LSB = 16;
    localparam int PM_OFF_HI_LSB = 48;
    localparam int FIELD16_W = 16;
    // Pin synchroniser depth
    localparam int SYNC_STAGES = 3;
    // Reset values
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [15:0] SEL_RESET = 16'h0000;

    // Event class reported with each entry
    typedef enum logic [2:0] {
        CLS_NONE = 3'b000,
        CLS_FAULT = 3'b001,
        CLS_TRAP = 3'b010,
        CLS_ABORT = 3'b011,
        CLS_SOFT = 3'b100,
        CLS_NMI = 3'b101,
        CLS_MASKABLE = 3'b110
    } event_class_e;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PUSH = 3'b001,
        ST_ACK = 3'b010,
        ST_FETCH = 3'b011,
        ST_GO = 3'b100
    } seq_state_e;
endpackage : irq_seq_pkg

/* logic/pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync
    import irq_seq_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Raw pins and filtered levels
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    // One chain and one filtered level per pin
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic [SYNC_STAGES-1:0] chain; // Stage 0 feeds only stage 1
        logic level; // Accepted level

        // Shift the pin through the chain
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                chain <= '0;
            end else begin
                chain <= {chain[SYNC_STAGES-2:0], pin_i[b]};
            end
        end

        // Update only when the last two stages agree
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                level <= 1'b0;
            end else if (chain[1] == chain[2]) begin
                level <= chain[2];
            end
        end

        assign level_o[b] = level;
    end
endmodule : pin_sync

/* logic/vector_locator.sv */
// Vector table entry address and handler pointer decode for both modes
`timescale 1ns/100ps
module vector_locator
    import irq_seq_pkg::*;
(
    // Lookup request
    input wire logic prot_mode_i,
    input wire logic [ADDR_W-1:0] table_base_i,
    input wire logic [VEC_W-1:0] vector_i,
    // Entry read back from the table
    input wire logic [ENTRY_W-1:0] entry_i,
    // Results
    output logic [ADDR_W-1:0] entry_addr_o,
    output logic [FIELD16_W-1:0] handler_sel_o,
    output logic [ADDR_W-1:0] handler_off_o
);
    logic [ADDR_W-1:0] vec_wide; // Vector zero-extended

    assign vec_wide = {{(ADDR_W-VEC_W){1'b0}}, vector_i};

    // Entry address: four bytes per entry in real mode, eight in protected
    always_comb begin
        if (prot_mode_i) begin
            entry_addr_o = table_base_i + (vec_wide << PROT_ENTRY_SHIFT);
        end else begin
            entry_addr_o = table_base_i + (vec_wide << REAL_ENTRY_SHIFT);
        end
    end

    // Real entry: segment plus 16-bit offset; protected: split offset and selector
    always_comb begin
        if (prot_mode_i) begin
            handler_sel_o = entry_i[PM_SEL_LSB +: FIELD16_W];
            handler_off_o = {entry_i[PM_OFF_HI_LSB +: FIELD16_W], entry_i[PM_OFF_LO_LSB +: FIELD16_W]};
        end else begin
            handler_sel_o = entry_i[RM_SEG_LSB +: FIELD16_W];
            handler_off_o = {{FIELD16_W{1'b0}}, entry_i[RM_OFF_LSB +: FIELD16_W]};
        end
    end
endmodule : vector_locator

/* testbench/irq_far_model.sv */
// Far side: stack, interrupt controller and vector table memory
`timescale 1ns/100ps
module irq_far_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Answer delay and vector handed out
    input wire logic [1:0] wait_i,
    input wire logic [7:0] vec_i,
    // Stack push
    input wire logic push_valid_i,
    output logic push_ready_o,
    // Acknowledge cycle
    input wire logic inta_req_i,
    output logic inta_done_o,
    output logic [7:0] inta_vec_o,
    // Table read
    input wire logic table_rd_i,
    input wire logic [31:0] table_addr_i,
    output logic table_ack_o,
    output logic [63:0] table_data_o
);
    logic [1:0] cnt; // Idle cycles waited
    logic [7:0] junk; // Moves every cycle
    logic [63:0] data; // Entry being returned
    // Released lines never hold the last value
    assign inta_vec_o = inta_done_o ? vec_i : junk;
    assign table_data_o = table_ack_o ? data : {8{junk}};
    // One answer per request after wait_i cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {cnt, junk, data} <= '0;
            {push_ready_o, inta_done_o, table_ack_o} <= '0;
        end else begin
            junk <= junk + 8'h3b;
            if (push_ready_o || inta_done_o || table_ack_o) begin
                {push_ready_o, inta_done_o, table_ack_o} <= '0;
                cnt <= '0;
            end else if (push_valid_i || inta_req_i || table_rd_i) begin
                if (cnt == wait_i) begin
                    push_ready_o <= push_valid_i;
                    inta_done_o <= inta_req_i;
                    table_ack_o <= table_rd_i;
                    data <= {~table_addr_i, table_addr_i};
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end
endmodule : irq_far_model

/* testbench/irq_seq_asserts.sv */
// Port-level checks on the interrupt and exception sequencer
`timescale 1ns/100ps
module irq_seq_asserts
    import irq_seq_pkg::*;
(
    // Clock, reset and core side
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic instr_boundary_i,
    input wire logic fault_i,
    input wire logic abort_i,
    input wire logic prot_mode_i,
    input wire logic [ADDR_W-1:0] table_base_i,
    input wire logic interrupt_return_instr_i,
    input wire logic [ADDR_W-1:0] ret_addr_i,
    input wire logic ret_if_i,
    // Far-side handshakes
    input wire logic push_valid_o,
    input wire logic push_ready_i,
    input wire logic inta_req_o,
    input wire logic table_rd_o,
    input wire logic table_ack_i,
    input wire logic [ADDR_W-1:0] table_addr_o,
    // Dispatch and state
    input wire logic busy_o,
    input wire logic handler_go_o,
    input wire logic [VEC_W-1:0] vector_o,
    input wire logic [2:0] event_class_o,
    input wire logic vec_reserved_o,
    input wire logic if_flag_o,
    input wire logic nmi_active_o,
    input wire logic resume_o,
    input wire logic [ADDR_W-1:0] resume_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Completed push and table reads
    sequence push_done_s;
        push_valid_o && push_ready_i;
    endsequence
    sequence table_done_s;
        table_rd_o && table_ack_i;
    endsequence
    push_first_a: assert property ($rose(busy_o) |-> push_valid_o)
        else $error("no push at entry");
    push_hold_a: assert property (push_valid_o && !push_ready_i |=> push_valid_o)
        else $error("push dropped early");
    take_point_a: assert property ($rose(busy_o) |->
        $past(instr_boundary_i) || $past(fault_i) || $past(abort_i))
        else $error("entry inside an instruction");
    ack_order_a: assert property ($rose(inta_req_o) |->
        $past(push_valid_o) && $past(push_ready_i) && event_class_o == CLS_MASKABLE)
        else $error("acknowledge out of order");
    // Only a maskable entry asks the controller; the rest go straight to the table
    push_next_a: assert property (push_done_s |=>
        inta_req_o == (event_class_o == CLS_MASKABLE) && table_rd_o == !inta_req_o)
        else $error("wrong step after push");
    go_after_a: assert property (table_done_s |=> handler_go_o)
        else $error("no dispatch after table read");
    nmi_vec_a: assert property (handler_go_o && event_class_o == CLS_NMI |-> vector_o == VEC_NMI && !if_flag_o)
        else $error("bad non-maskable entry");
    tbl_addr_a: assert property (table_rd_o |-> table_addr_o == table_base_i
        + (prot_mode_i ? {21'h0, vector_o, 3'h0} : {22'h0, vector_o, 2'h0}))
        else $error("bad entry address");
    // Reserved range is the bottom 32 vectors: top three bits all zero
    rsv_flag_a: assert property (vec_reserved_o == (vector_o[7:5] == 3'h0))
        else $error("bad reserved flag");
    ret_state_a: assert property (interrupt_return_instr_i && !busy_o |=>
        resume_o && !nmi_active_o && resume_addr_o == $past(ret_addr_i) && if_flag_o == $past(ret_if_i))
        else $error("bad return");
endmodule : irq_seq_asserts

bind interrupt_exception_sequencer irq_seq_asserts u_chk (.*);

/* testbench/tb_top.sv */
// Self-checking bench for the interrupt and exception sequencer
`timescale 1ns/100ps
module tb_top;
    import irq_seq_pkg::*;
    // Driven inputs
    logic clk_i = 1'b0, rst_n_i = 1'b0, nmi_in_i = 1'b0, maskable_irq_in_i = 1'b0;
    logic instr_boundary_i = 1'b1, prot_mode_i = 1'b0, if_set_i = 1'b0, if_clear_i = 1'b0;
    logic fault_i = 1'b0, trap_i = 1'b0, abort_i = 1'b0, soft_int_i = 1'b0;
    logic interrupt_return_instr_i = 1'b0, ret_if_i = 1'b0;
    logic [31:0] instr_start_addr_i = 32'h0000_0100, next_instr_addr_i = 32'h0000_0103;
    logic [31:0] table_base_i = '0, ret_addr_i = '0;
    logic [7:0] fault_vec_i = '0, trap_vec_i = '0, abort_vec_i = '0, soft_int_vec_i = '0, mv = '0, v;
    logic [1:0] mw = '0;
    // Design outputs and far-side answers
    logic push_valid_o, push_ready_i, push_if_o, inta_req_o, inta_done_i, table_rd_o, table_ack_i;
    logic busy_o, handler_go_o, vec_reserved_o, if_flag_o, nmi_active_o, resume_o;
    logic [31:0] push_addr_o, table_addr_o, handler_off_o, resume_addr_o, pa, e;
    logic [7:0] inta_vec_i, vector_o;
    logic [63:0] table_data_i;
    logic [15:0] handler_sel_o;
    logic [2:0] event_class_o;
    logic [2:0] cls_tab [4] = '{CLS_SOFT, CLS_TRAP, CLS_FAULT, CLS_ABORT};
    logic [31:0] seed = 32'h0000_288f;
    int fails = 0, check_count = 0, cyc = 0;

    interrupt_exception_sequencer u_dut (.*);
    irq_far_model u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .wait_i(mw), .vec_i(mv),
        .push_valid_i(push_valid_o), .push_ready_o(push_ready_i), .inta_req_i(inta_req_o),
        .inta_done_o(inta_done_i), .inta_vec_o(inta_vec_i), .table_rd_i(table_rd_o),
        .table_addr_i(table_addr_o), .table_ack_o(table_ack_i), .table_data_o(table_data_i));

    // Clock, pushed address capture and run limit
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (push_valid_o && push_ready_i) begin
            pa <= push_addr_o;
        end
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Expected entry address of a vector
    function automatic logic [31:0] ent(input logic [7:0] x);
        return table_base_i + (prot_mode_i ? {21'h0, x, 3'h0} : {22'h0, x, 2'h0});
    endfunction : ent

    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    // No entry may start for n cycles
    task automatic idle(input int n);
        bit ok;
        ok = 1'b1;
        repeat (n) begin
            @(negedge clk_i);
            ok &= (busy_o === 1'b0);
        end
        chk(ok, "unexpected entry");
        // Hand back on a rising edge so callers drive there
        @(posedge clk_i);
    endtask : idle
    // One-cycle core event with fresh addresses and table setup
    task automatic ev(input logic [3:0] m, input logic [7:0] x);
        @(posedge clk_i);
        {abort_i, fault_i, trap_i, soft_int_i} <= m;
        {abort_vec_i, fault_vec_i, trap_vec_i, soft_int_vec_i} <= {4{x}};
        instr_start_addr_i <= seed;
        next_instr_addr_i <= seed + 32'h0000_0003;
        prot_mode_i <= seed[2];
        table_base_i <= {seed[31:8], 8'h00};
        mw <= seed[4:3];
        @(posedge clk_i);
        {abort_i, fault_i, trap_i, soft_int_i} <= 4'h0;
    endtask : ev
    // Wait for dispatch and compare what it carries
    task automatic go_wait(input logic [2:0] c, input logic [7:0] x, input logic [31:0] p);
        int n;
        n = 0;
        while (handler_go_o !== 1'b1 && n < 80) begin
            @(negedge clk_i);
            n++;
        end
        e = ent(x);
        chk(handler_go_o === 1'b1 && event_class_o === c && vector_o === x && pa === p, "dispatch");
        chk(handler_sel_o === e[31:16] && handler_off_o[15:0] === e[15:0], "handler");
        chk(handler_off_o[31:16] === (prot_mode_i ? ~e[31:16] : 16'h0000), "handler high");
        // Only the hardware entries here start with the enable flag set
        chk(push_if_o === (c == CLS_NMI || c == CLS_MASKABLE), "pushed flag");
        repeat (3) @(posedge clk_i);
    endtask : go_wait
    // Return pulse and resumed state
    task automatic ret(input logic f);
        seed = lfsr(seed);
        @(posedge clk_i);
        interrupt_return_instr_i <= 1'b1;
        ret_addr_i <= seed;
        ret_if_i <= f;
        @(posedge clk_i);
        interrupt_return_instr_i <= 1'b0;
        @(negedge clk_i);
        chk(resume_o === 1'b1 && resume_addr_o === ret_addr_i && if_flag_o === f, "resume");
    endtask : ret
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        mv <= 8'hc5;
        repeat (4) @(posedge clk_i);
        // Enable set then cleared again before the request rises
        if_set_i <= 1'b1;
        @(posedge clk_i);
        {if_set_i, if_clear_i} <= 2'b01;
        @(posedge clk_i);
        if_clear_i <= 1'b0;
        // Held request with enable clear is ignored
        maskable_irq_in_i <= 1'b1;
        idle(20);
        // Both pins wait for the same boundary
        instr_boundary_i <= 1'b0;
        if_set_i <= 1'b1;
        @(posedge clk_i);
        if_set_i <= 1'b0;
        nmi_in_i <= 1'b1;
        idle(12);
        @(posedge clk_i);
        instr_boundary_i <= 1'b1;
        go_wait(CLS_NMI, VEC_NMI, next_instr_addr_i);
        chk(if_flag_o === 1'b0 && nmi_active_o === 1'b1, "nmi flags");
        // Second edge during handling stays pending
        nmi_in_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        nmi_in_i <= 1'b1;
        idle(20);
        ret(1'b1);
        go_wait(CLS_NMI, VEC_NMI, next_instr_addr_i);
        ret(1'b1);
        go_wait(CLS_MASKABLE, 8'hc5, next_instr_addr_i);
        chk(if_flag_o === 1'b0, "enable after entry");
        maskable_irq_in_i <= 1'b0;
        nmi_in_i <= 1'b0;
        ret(1'b0);
        // Abort outranks a fault raised with it
        ev(4'hc, 8'h08);
        go_wait(CLS_ABORT, 8'h08, instr_start_addr_i);
        // Random exceptions and software interrupts in both table modes
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h1f : (i == 2) ? 8'h20 : seed[15:8];
            ev(4'h1 << (i % 4), v);
            go_wait(cls_tab[i % 4], v, (i % 4 > 1) ? instr_start_addr_i : next_instr_addr_i);
        end
        complete_run();
    end
endmodule : tb_top
